/* src/sac_cfg.svh */
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// Clock period of the controller in ns (20 MHz)
`define SAC_CLK_NS 50

// Memory timing, fastest grade, in ns
`define SAC_T_AA_NS   10
`define SAC_T_WP_NS   7
`define SAC_T_DW_NS   5
`define SAC_T_AW_NS   7
`define SAC_T_WR_NS   0
`define SAC_T_DH_NS   0
`define SAC_T_CHZ_NS  5
`define SAC_T_WHZ_NS  5

// Least time in ns to whole cycles, rounded up, never below one
`define SAC_CEIL_CYC(t) ((((t) + `SAC_CLK_NS - 1) / `SAC_CLK_NS) < 1 ? 1 : \
                         (((t) + `SAC_CLK_NS - 1) / `SAC_CLK_NS))
`define SAC_MAX(a, b) ((a) > (b) ? (a) : (b))

`define SAC_AA_CYC   `SAC_CEIL_CYC(`SAC_T_AA_NS)
`define SAC_WP_CYC   `SAC_CEIL_CYC(`SAC_MAX(`SAC_MAX(`SAC_T_WP_NS, `SAC_T_DW_NS), `SAC_T_AW_NS))
`define SAC_HOLD_CYC `SAC_CEIL_CYC(`SAC_MAX(`SAC_T_WR_NS, `SAC_T_DH_NS))
`define SAC_TURN_CYC `SAC_CEIL_CYC(`SAC_MAX(`SAC_T_CHZ_NS, `SAC_T_WHZ_NS))

// Flip-flops on the data pins before the read value is used
`define SAC_SYNC_STAGES 2

// Reset values
`define SAC_RST_PIN_N 1'b1
`define SAC_RST_ADDR  16'h0000
`define SAC_RST_DATA  16'h0000
`define SAC_RST_CNT   4'h0

`endif

/* src/sac_ctrl.sv */
`timescale 1ns/100ps
`include "sac_cfg.svh"
module sac_ctrl (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // User request
  input  wire logic                req_valid,
  input  wire logic                req_write,
  input  wire sac_pkg::sac_addr_t  req_addr,
  input  wire sac_pkg::sac_word_t  req_wdata,
  input  wire sac_pkg::sac_lanes_t req_lanes,
  output logic                     req_ready,
  // Read answer
  output sac_pkg::sac_word_t       rsp_rdata,
  output logic                     rsp_valid,
  // Memory pins
  output sac_pkg::sac_addr_t       word_addr,
  output logic                     sel_n,
  output logic                     write_n,
  output logic                     out_drive_n,
  output logic                     lower_lane_en_n,
  output logic                     upper_lane_en_n,
  output sac_pkg::sac_word_t       data_out,
  output logic                     data_oe_n,
  input  wire sac_pkg::sac_word_t  data_in
);
  import sac_pkg::*;

  localparam sac_cnt_t RD_CNT   = 4'(`SAC_AA_CYC + `SAC_SYNC_STAGES);
  localparam sac_cnt_t WP_CNT   = 4'(`SAC_WP_CYC);
  localparam sac_cnt_t HOLD_CNT = 4'(`SAC_HOLD_CYC);
  localparam sac_cnt_t TURN_CNT = 4'(`SAC_TURN_CYC);

  sac_state_t state;
  sac_state_t next_state;
  sac_cnt_t   cnt;
  sac_cnt_t   next_cnt;
  logic       next_req_ready;
  sac_word_t  next_rsp_rdata;
  logic       next_rsp_valid;
  sac_addr_t  next_word_addr;
  logic       next_sel_n;
  logic       next_write_n;
  logic       next_out_drive_n;
  logic       next_lower_lane_en_n;
  logic       next_upper_lane_en_n;
  sac_word_t  next_data_out;
  logic       next_data_oe_n;
  sac_word_t  data_sync;

  // Read data comes from an unclocked part, so it is resynchronised
  sac_sync #(
    .W(16)
  ) u_data_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (data_in),
    .sync_out (data_sync)
  );

  always_comb begin
    next_state           = state;
    next_cnt             = cnt;
    next_rsp_rdata       = rsp_rdata;
    next_rsp_valid       = 1'b0;
    next_word_addr       = word_addr;
    next_sel_n           = sel_n;
    next_write_n         = write_n;
    next_out_drive_n     = out_drive_n;
    next_lower_lane_en_n = lower_lane_en_n;
    next_upper_lane_en_n = upper_lane_en_n;
    next_data_out        = data_out;
    next_data_oe_n       = data_oe_n;
    unique case (state)
      SAC_IDLE: begin
        if (req_valid && req_ready) begin
          // Address, select and lanes change together, never address later
          next_word_addr       = req_addr;
          next_sel_n           = 1'b0;
          next_lower_lane_en_n = ~req_lanes[0];
          next_upper_lane_en_n = ~req_lanes[1];
          if (req_write) begin
            // Bus is free here: every read ends with a turnaround gap
            next_data_out  = req_wdata;
            next_data_oe_n = 1'b0;
            next_state     = SAC_WR_SETUP;
          end else begin
            next_out_drive_n = 1'b0;
            next_cnt         = RD_CNT;
            next_state       = SAC_RD_ACC;
          end
        end
      end
      SAC_RD_ACC: begin
        if (cnt == 4'h1) begin
          next_rsp_rdata       = data_sync;
          next_rsp_valid       = 1'b1;
          next_sel_n           = 1'b1;
          next_out_drive_n     = 1'b1;
          next_lower_lane_en_n = 1'b1;
          next_upper_lane_en_n = 1'b1;
          next_cnt             = TURN_CNT;
          next_state           = SAC_TURN;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      SAC_TURN: begin
        if (cnt == 4'h1) begin
          next_state = SAC_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      SAC_WR_SETUP: begin
        // Output drive stays high, so the plain pulse width is enough
        next_write_n = 1'b0;
        next_cnt     = WP_CNT;
        next_state   = SAC_WR_PULSE;
      end
      SAC_WR_PULSE: begin
        if (cnt == 4'h1) begin
          next_write_n = 1'b1;
          next_cnt     = HOLD_CNT;
          next_state   = SAC_WR_HOLD;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      SAC_WR_HOLD: begin
        if (cnt == 4'h1) begin
          // Address and data are held past the strobe edge
          next_sel_n           = 1'b1;
          next_lower_lane_en_n = 1'b1;
          next_upper_lane_en_n = 1'b1;
          next_data_oe_n       = 1'b1;
          next_state           = SAC_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
    endcase
    next_req_ready = (next_state == SAC_IDLE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state           <= SAC_IDLE;
      cnt             <= `SAC_RST_CNT;
      req_ready       <= 1'b0;
      rsp_rdata       <= `SAC_RST_DATA;
      rsp_valid       <= 1'b0;
      word_addr       <= `SAC_RST_ADDR;
      sel_n           <= `SAC_RST_PIN_N;
      write_n         <= `SAC_RST_PIN_N;
      out_drive_n     <= `SAC_RST_PIN_N;
      lower_lane_en_n <= `SAC_RST_PIN_N;
      upper_lane_en_n <= `SAC_RST_PIN_N;
      data_out        <= `SAC_RST_DATA;
      data_oe_n       <= `SAC_RST_PIN_N;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      req_ready       <= next_req_ready;
      rsp_rdata       <= next_rsp_rdata;
      rsp_valid       <= next_rsp_valid;
      word_addr       <= next_word_addr;
      sel_n           <= next_sel_n;
      write_n         <= next_write_n;
      out_drive_n     <= next_out_drive_n;
      lower_lane_en_n <= next_lower_lane_en_n;
      upper_lane_en_n <= next_upper_lane_en_n;
      data_out        <= next_data_out;
      data_oe_n       <= next_data_oe_n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // The address moves on the select edge itself, so it is only held from the next cycle on
  sequence rd_held_s;
    (!sel_n && !out_drive_n && write_n)[*1] ##1
    (!sel_n && !out_drive_n && write_n && $stable(word_addr))[*2];
  endsequence

  sequence bus_released_s;
    sel_n && out_drive_n && data_oe_n;
  endsequence

  sequence wr_strobe_s;
    (!write_n && !data_oe_n && out_drive_n)[*1] ##1 (write_n && !data_oe_n);
  endsequence

  no_clash_a: assert property (!data_oe_n |-> out_drive_n)
    else $error("write data driven while memory output enabled");

  read_turn_a: assert property ($rose(out_drive_n) |-> bus_released_s ##1 data_oe_n)
    else $error("bus driven too soon after read");

  strobe_oe_a: assert property ($fell(write_n) |-> wr_strobe_s)
    else $error("write strobe width or output drive wrong");

  addr_setup_a: assert property ($fell(write_n) |-> $stable(word_addr) && !sel_n)
    else $error("address or select not set before strobe");

  addr_hold_a: assert property ($rose(write_n) |-> $stable(word_addr) && !sel_n)
    else $error("address changed at end of write");

  data_hold_a: assert property (!write_n ##1 write_n |-> $stable(data_out) && !data_oe_n)
    else $error("write data not held through strobe end");

  data_setup_a: assert property ($fell(write_n) |-> !$past(data_oe_n))
    else $error("write data not driven before strobe");

  // Writes also lower select with the strobe still high; only reads lower output drive
  read_hold_a: assert property ($fell(sel_n) && !out_drive_n |-> rd_held_s ##1 rsp_valid)
    else $error("read pins not held for access and sync time");
endmodule

/* src/sac_pkg.sv */
package sac_pkg;
  typedef logic [15:0] sac_word_t;
  typedef logic [15:0] sac_addr_t;
  typedef logic [1:0]  sac_lanes_t;
  typedef logic [3:0]  sac_cnt_t;
  typedef enum logic [2:0] {
    SAC_IDLE,
    SAC_RD_ACC,
    SAC_TURN,
    SAC_WR_SETUP,
    SAC_WR_PULSE,
    SAC_WR_HOLD
  } sac_state_t;
endpackage

/* src/sac_sync.sv */
`timescale 1ns/100ps
module sac_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Asynchronous input and its synchronised copy
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // The first stage feeds the second only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* verif/async_sram_64k_x16_byte_lanes_tb_top.sv */
`timescale 1ns/100ps
module async_sram_64k_x16_byte_lanes_tb_top;
  import sac_pkg::*;
  logic       clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  sac_addr_t  req_addr = 16'h0000, word_addr;
  sac_word_t  req_wdata = 16'h0000, rsp_rdata, data_out, bus, mq, junk = 16'h0000;
  sac_lanes_t req_lanes = 2'h0;
  logic       req_ready, rsp_valid, sel_n, write_n, out_drive_n, lo_n, hi_n, data_oe_n;
  logic       d_lo, d_hi;
  int         n_errors = 0, n_checks = 0, cyc = 0;

  // Released lanes show a pattern that moves every cycle
  assign bus = !data_oe_n ? data_out :
               {d_hi ? mq[15:8] : junk[15:8], d_lo ? mq[7:0] : junk[7:0]};
  always @(posedge clk) junk <= ~junk + 16'h1357;

  sac_ctrl uut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes), .req_ready(req_ready),
    .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .word_addr(word_addr), .sel_n(sel_n),
    .write_n(write_n), .out_drive_n(out_drive_n), .lower_lane_en_n(lo_n),
    .upper_lane_en_n(hi_n), .data_out(data_out), .data_oe_n(data_oe_n), .data_in(bus));
  sac_sram_model mem_i (.word_addr(word_addr), .sel_n(sel_n), .write_n(write_n),
    .out_drive_n(out_drive_n), .lower_lane_en_n(lo_n), .upper_lane_en_n(hi_n),
    .dq_in(bus), .dq_out(mq), .drv_lo(d_lo), .drv_hi(d_hi));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(sac_word_t got, sac_word_t exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until an edge sees req_ready high
  task automatic xfer(logic w, sac_addr_t a, sac_word_t d, sac_lanes_t l);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_lanes = l;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    if (n >= 50) n_errors++;
    // One edge passes with the request low, so a following call never re-raises it at once
    @(posedge clk);
    #1;
  endtask

  task automatic rd(sac_addr_t a, sac_lanes_t l, sac_word_t exp);
    sac_word_t m;
    int n;
    m = {{8{l[1]}}, {8{l[0]}}};
    n = 0;
    xfer(1'b0, a, 16'h0000, l);
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(rsp_valid === 1'b1 ? rsp_rdata & m : ~exp & m, exp & m);
  endtask

  task automatic t_idle;
    check({10'h000, sel_n, write_n, out_drive_n, lo_n, hi_n, data_oe_n}, 16'h003f);
    $display("test idle done");
  endtask

  task automatic t_word;
    xfer(1'b1, 16'h0000, 16'ha55a, 2'h3);
    xfer(1'b1, 16'hffff, 16'h3cc3, 2'h3);
    rd(16'h0000, 2'h3, 16'ha55a);
    rd(16'hffff, 2'h3, 16'h3cc3);
    rd(16'h0000, 2'h3, 16'ha55a);
    $display("test word done");
  endtask

  task automatic t_lanes;
    xfer(1'b1, 16'h1234, 16'h0000, 2'h3);
    xfer(1'b1, 16'h1234, 16'h11ab, 2'h1);
    xfer(1'b1, 16'h1234, 16'hcd22, 2'h2);
    xfer(1'b1, 16'h1234, 16'hffff, 2'h0);
    rd(16'h1234, 2'h3, 16'hcdab);
    rd(16'h1234, 2'h1, 16'hcdab);
    rd(16'h1234, 2'h2, 16'hcdab);
    $display("test lanes done");
  endtask

  // Both parties driving the data bus at once
  always @(negedge clk) begin
    if (reset_n && !data_oe_n && (d_lo || d_hi)) check(16'h0001, 16'h0000);
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    @(posedge clk);
    #1;
    t_idle();
    t_word();
    t_lanes();
    give_verdict();
  end
endmodule

/* verif/sac_sram_model.sv */
`timescale 1ns/100ps
module sac_sram_model (
  // Memory pins
  input  wire logic [15:0] word_addr,
  input  wire logic        sel_n,
  input  wire logic        write_n,
  input  wire logic        out_drive_n,
  input  wire logic        lower_lane_en_n,
  input  wire logic        upper_lane_en_n,
  // Data bus level and the memory's own drive
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic             drv_lo,
  output logic             drv_hi
);
  import sac_pkg::*;
  // No clock and no refresh: contents live as long as the array
  sac_word_t mem [0:65535];
  logic      rd_on;
  // Strobe low keeps the drivers off, whatever the select order
  assign rd_on = !sel_n && !out_drive_n && write_n;
  assign #10 dq_out = mem[word_addr];
  // One delay for both edges: on within 5 ns, off within 5, never before 3
  assign #5 drv_lo = rd_on && !lower_lane_en_n;
  assign #5 drv_hi = rd_on && !upper_lane_en_n;
  // Level write during the overlap; a disabled lane is left alone
  always @* begin
    if (!sel_n && !write_n) begin
      if (!lower_lane_en_n) mem[word_addr][7:0] = dq_in[7:0];
      if (!upper_lane_en_n) mem[word_addr][15:8] = dq_in[15:8];
    end
  end
endmodule
